// File: src/bdrc_pkg.sv
// Package of constants and types for the step-down rail ramp control block
package bdrc_pkg;

    localparam int          BDRC_CLK_MHZ       = 100;
    localparam int          BDRC_STEP10_NS     = 3000;
    localparam int          BDRC_STEP25_NS     = 6000;
    localparam int          BDRC_SOFT_START_US = 200;
    localparam int          BDRC_STEP10_CYC    = (BDRC_STEP10_NS * BDRC_CLK_MHZ) / 1000;
    localparam int          BDRC_STEP25_CYC    = (BDRC_STEP25_NS * BDRC_CLK_MHZ) / 1000;
    localparam int          BDRC_SOFT_CYC      = BDRC_SOFT_START_US * BDRC_CLK_MHZ;
    localparam int          BDRC_TMR_W         = 16;
    localparam int          BDRC_CODE_W        = 7;
    localparam int          BDRC_LCODE_W       = 4;
    localparam int          BDRC_ADDR_W        = 8;
    localparam int          BDRC_DATA_W        = 8;
    localparam int          BDRC_RAILS         = 6;

    localparam logic [7:0]  BDRC_OFS_LDO_A     = 8'h9a;
    localparam logic [7:0]  BDRC_OFS_LDO_B     = 8'h9b;
    localparam logic [7:0]  BDRC_OFS_LDO_C     = 8'hae;

    localparam logic [6:0]  BDRC_CODE_OFF      = 7'h00;
    localparam logic [6:0]  BDRC_CODE_MIN      = 7'h01;
    localparam logic [6:0]  BDRC_CODE_HALF_V   = 7'h04;
    localparam logic [3:0]  BDRC_LDO1_UNUSED   = 4'hf;
    localparam logic [3:0]  BDRC_LDO_RST       = 4'h0;

    // LDO one output in millivolts per code
    localparam logic [11:0] BDRC_LDO1_MV [16] = '{
        12'd1350, 12'd1500, 12'd1600, 12'd1700, 12'd1800, 12'd1900, 12'd2000, 12'd2100,
        12'd2300, 12'd2400, 12'd2500, 12'd2600, 12'd2850, 12'd3000, 12'd3300, 12'd0};

    typedef enum logic [2:0] {
        BDRC_IDLE  = 3'b000,
        BDRC_STEP  = 3'b001,
        BDRC_SOFT  = 3'b011,
        BDRC_DECAY = 3'b010,
        BDRC_OFF   = 3'b110
    } bdrc_state_t;

    typedef enum logic [1:0] {
        BDRC_SW_IDLE = 2'b00,
        BDRC_SW_HIGH = 2'b01,
        BDRC_SW_LOW  = 2'b11
    } bdrc_sw_t;

endpackage : bdrc_pkg

// File: src/bdrc_buck_dvs_ramp_control.sv
// Step-down rail voltage ramp, decay, soft start, pulse and LDO code control
`timescale 1ns/1ps

// Function
// - Six rails each scale voltage by a 7-bit code, 10mV or 25mV steps.
// - Code advances one step every 3us for 10mV, 6us for 25mV.
// - Force PWM while stepping the code unless decay enable is set; not during soft start.
// - Mask power good while a move is in progress.
// - Zero code without decay enable: step to minimum code, then stop switching.
// - From below 0.5V, soft start 200us to 0.5V, then ramp normally.
// - Decay stops both switches on downward moves only, no slew.
// - During decay, mask power good until output below new over-voltage level.
// - Upward code during decay waits until stepping code reaches output.
// - Comparator low starts high side; ends on min on-time and trip, or limit.
// - PWM mode allows negative inductor current for continuous conduction.
// - Host writes 4-bit LDO codes in bits 3:0 of three registers.
// - First LDO code decodes 1.35V to 3.3V; code 1111 unused.
// - Always-on first LDO stays enabled in emergency shutdown while supply valid.
module bdrc_buck_dvs_ramp_control
    import bdrc_pkg::*;
#(
    parameter int                          NUM_RAILS  = bdrc_pkg::BDRC_RAILS,
    parameter int                          SOFT_CYC   = bdrc_pkg::BDRC_SOFT_CYC
) (
    input  wire logic                             i_sys_clk,
    input  wire logic                             i_reset_n,
    input  wire logic [bdrc_pkg::BDRC_CODE_W-1:0] i_buck_voltage_code [NUM_RAILS],
    input  wire logic [NUM_RAILS-1:0]             i_code_write,
    input  wire logic [NUM_RAILS-1:0]             i_fine_step,
    input  wire logic [NUM_RAILS-1:0]             i_decay_enable,
    input  wire logic [NUM_RAILS-1:0]             i_out_below_half,
    input  wire logic [NUM_RAILS-1:0]             i_out_below_ov,
    input  wire logic [NUM_RAILS-1:0]             i_out_below_code,
    input  wire logic [NUM_RAILS-1:0]             i_error_cmp_low,
    input  wire logic [NUM_RAILS-1:0]             i_current_limit,
    input  wire logic [NUM_RAILS-1:0]             i_min_on_done,
    input  wire logic [NUM_RAILS-1:0]             i_power_good_raw,
    input  wire logic [NUM_RAILS-1:0]             i_rail_enable,
    input  wire logic [bdrc_pkg::BDRC_ADDR_W-1:0] i_reg_addr,
    input  wire logic [bdrc_pkg::BDRC_DATA_W-1:0] i_reg_wdata,
    input  wire logic                             i_reg_write,
    input  wire logic                             i_reg_read,
    input  wire logic                             i_ldo1_always_on,
    input  wire logic                             i_ldo1_enable,
    input  wire logic                             i_emergency_shutdown,
    input  wire logic                             i_supply_valid,
    output logic [bdrc_pkg::BDRC_CODE_W-1:0]      o_voltage_code [NUM_RAILS],
    output logic [NUM_RAILS-1:0]                  o_force_pwm,
    output logic [NUM_RAILS-1:0]                  o_allow_neg_current,
    output logic [NUM_RAILS-1:0]                  o_switching_off,
    output logic [NUM_RAILS-1:0]                  o_soft_start,
    output logic [NUM_RAILS-1:0]                  o_move_active,
    output logic [NUM_RAILS-1:0]                  o_power_good_flag,
    output logic [NUM_RAILS-1:0]                  o_high_side_on,
    output logic [NUM_RAILS-1:0]                  o_low_side_on,
    output logic [bdrc_pkg::BDRC_DATA_W-1:0]      o_reg_rdata,
    output logic [bdrc_pkg::BDRC_LCODE_W-1:0]     o_ldo_voltage_code [3],
    output logic [11:0]                           o_ldo1_mv,
    output logic                                  o_ldo1_on
);

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    localparam int NS = 8;
    logic [NUM_RAILS-1:0] sync1_r [NS];
    logic [NUM_RAILS-1:0] sync2_r [NS];
    logic [NUM_RAILS-1:0] pin_raw [NS];
    logic [2:0]           esd_s1_r, esd_s2_r;

    assign pin_raw[0] = i_out_below_half;
    assign pin_raw[1] = i_out_below_ov;
    assign pin_raw[2] = i_out_below_code;
    assign pin_raw[3] = i_error_cmp_low;
    assign pin_raw[4] = i_current_limit;
    assign pin_raw[5] = i_min_on_done;
    assign pin_raw[6] = i_power_good_raw;
    assign pin_raw[7] = i_rail_enable;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            for (int k = 0; k < NS; k++) begin
                sync1_r[k] <= '0;
                sync2_r[k] <= '0;
            end
            esd_s1_r <= '0;
            esd_s2_r <= '0;
        end else begin
            for (int k = 0; k < NS; k++) begin
                sync1_r[k] <= pin_raw[k];
                sync2_r[k] <= sync1_r[k];
            end
            esd_s1_r <= {i_emergency_shutdown, i_supply_valid, i_ldo1_enable};
            esd_s2_r <= esd_s1_r;
        end
    end

    // ----------------------------------------
    // LDO code registers
    // ----------------------------------------
    logic [BDRC_LCODE_W-1:0] ldo_r [3];
    logic [BDRC_LCODE_W-1:0] ldo_nxt [3];
    logic [BDRC_DATA_W-1:0]  rdata_r, rdata_nxt;

    always_comb begin
        ldo_nxt   = ldo_r;
        rdata_nxt = rdata_r;
        if (i_reg_write) begin
            if (i_reg_addr == BDRC_OFS_LDO_A) begin
                ldo_nxt[0] = i_reg_wdata[BDRC_LCODE_W-1:0];
            end else if (i_reg_addr == BDRC_OFS_LDO_B) begin
                ldo_nxt[1] = i_reg_wdata[BDRC_LCODE_W-1:0];
            end else if (i_reg_addr == BDRC_OFS_LDO_C) begin
                ldo_nxt[2] = i_reg_wdata[BDRC_LCODE_W-1:0];
            end
        end
        if (i_reg_read) begin
            if (i_reg_addr == BDRC_OFS_LDO_A) begin
                rdata_nxt = {4'h0, ldo_r[0]};
            end else if (i_reg_addr == BDRC_OFS_LDO_B) begin
                rdata_nxt = {4'h0, ldo_r[1]};
            end else if (i_reg_addr == BDRC_OFS_LDO_C) begin
                rdata_nxt = {4'h0, ldo_r[2]};
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            for (int k = 0; k < 3; k++) begin
                ldo_r[k] <= BDRC_LDO_RST;
            end
            rdata_r <= '0;
        end else begin
            ldo_r   <= ldo_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_reg_rdata        = rdata_r;
    assign o_ldo_voltage_code = ldo_r;

    // First LDO decode and always-on behaviour
    logic        ldo1_on_r, ldo1_on_nxt;
    logic [11:0] ldo1_mv_r, ldo1_mv_nxt;

    always_comb begin
        ldo1_mv_nxt = BDRC_LDO1_MV[ldo_r[0]];
        if (ldo_r[0] == BDRC_LDO1_UNUSED) begin
            ldo1_mv_nxt = ldo1_mv_r;
        end
        ldo1_on_nxt = esd_s2_r[0] && !esd_s2_r[2];
        if (i_ldo1_always_on && esd_s2_r[1]) begin
            ldo1_on_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            ldo1_on_r <= 1'b0;
            ldo1_mv_r <= '0;
        end else begin
            ldo1_on_r <= ldo1_on_nxt;
            ldo1_mv_r <= ldo1_mv_nxt;
        end
    end

    assign o_ldo1_mv = ldo1_mv_r;
    assign o_ldo1_on = ldo1_on_r;

    // ----------------------------------------
    // Per-rail stepper and pulse control
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_RAILS; g++) begin : g_rail
            bdrc_state_t             st_r, st_nxt;
            bdrc_sw_t                sw_r, sw_nxt;
            logic [BDRC_CODE_W-1:0]  code_r, code_nxt;
            logic [BDRC_CODE_W-1:0]  tgt_r, tgt_nxt;
            logic [BDRC_TMR_W-1:0]   tmr_r, tmr_nxt;
            logic [BDRC_TMR_W-1:0]   intv;
            logic [BDRC_CODE_W-1:0]  wcode;
            logic                    pg_r, pg_nxt;

            assign wcode = i_buck_voltage_code[g];
            assign intv = i_fine_step[g] ? BDRC_TMR_W'(BDRC_STEP10_CYC - 1)
                                         : BDRC_TMR_W'(BDRC_STEP25_CYC - 1);

            always_comb begin
                st_nxt  = st_r;
                code_nxt = code_r;
                tgt_nxt = tgt_r;
                tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : '0;
                case (st_r)
                    BDRC_IDLE, BDRC_OFF: begin
                    end
                    BDRC_SOFT: begin
                        if (tmr_r == '0) begin
                            code_nxt = BDRC_CODE_HALF_V;
                            st_nxt   = BDRC_STEP;
                            tmr_nxt  = intv;
                        end
                    end
                    BDRC_DECAY: begin
                        if (tgt_r > code_r) begin
                            // Wait until the ramp meets the decaying output
                            if (tmr_r == '0) begin
                                tmr_nxt = intv;
                                if (sync2_r[2][g]) begin
                                    st_nxt = BDRC_STEP;
                                end else begin
                                    code_nxt = code_r + 1'b1;
                                end
                            end
                        end else if (sync2_r[1][g]) begin
                            st_nxt = BDRC_IDLE;
                        end
                    end
                    default: begin
                        if (tmr_r == '0) begin
                            tmr_nxt = intv;
                            if (code_r < tgt_r) begin
                                code_nxt = code_r + 1'b1;
                            end else if (code_r > tgt_r) begin
                                code_nxt = code_r - 1'b1;
                            end
                            if (code_nxt == tgt_r) begin
                                st_nxt = (tgt_r == BDRC_CODE_MIN && wcode == BDRC_CODE_OFF)
                                         ? BDRC_OFF : BDRC_IDLE;
                            end
                        end
                    end
                endcase
                if (i_code_write[g]) begin
                    // Zero code targets the minimum code first
                    tgt_nxt = (wcode == BDRC_CODE_OFF) ? BDRC_CODE_MIN : wcode;
                    tmr_nxt = intv;
                    if (wcode != BDRC_CODE_OFF && wcode != BDRC_CODE_MIN
                        && sync2_r[0][g] && st_r != BDRC_DECAY) begin
                        st_nxt  = BDRC_SOFT;
                        tmr_nxt = BDRC_TMR_W'(SOFT_CYC - 1);
                    end else if (i_decay_enable[g] && tgt_nxt < code_r) begin
                        st_nxt   = BDRC_DECAY;
                        code_nxt = tgt_nxt;
                    end else if (st_r == BDRC_DECAY && tgt_nxt > code_r) begin
                        st_nxt = BDRC_DECAY;
                    end else if (tgt_nxt != code_r) begin
                        st_nxt = BDRC_STEP;
                    end else begin
                        st_nxt = (wcode == BDRC_CODE_OFF) ? BDRC_OFF : BDRC_IDLE;
                    end
                end
            end

            // Hysteretic pulse decision
            always_comb begin
                sw_nxt = sw_r;
                case (sw_r)
                    BDRC_SW_IDLE: begin
                        if (sync2_r[3][g]) begin
                            sw_nxt = BDRC_SW_HIGH;
                        end
                    end
                    BDRC_SW_HIGH: begin
                        if ((sync2_r[5][g] && !sync2_r[3][g]) || sync2_r[4][g]) begin
                            sw_nxt = BDRC_SW_LOW;
                        end
                    end
                    default: begin
                        if (sync2_r[3][g]) begin
                            sw_nxt = BDRC_SW_HIGH;
                        end
                    end
                endcase
                if (st_r == BDRC_DECAY || st_r == BDRC_OFF || st_r == BDRC_SOFT
                    || !sync2_r[7][g]) begin
                    sw_nxt = BDRC_SW_IDLE;
                end
                pg_nxt = sync2_r[6][g] && (st_nxt == BDRC_IDLE);
            end

            always_ff @(posedge i_sys_clk) begin
                if (!i_reset_n) begin
                    st_r   <= BDRC_OFF;
                    sw_r   <= BDRC_SW_IDLE;
                    code_r <= BDRC_CODE_OFF;
                    tgt_r  <= BDRC_CODE_OFF;
                    tmr_r  <= '0;
                    pg_r   <= 1'b0;
                end else begin
                    st_r   <= st_nxt;
                    sw_r   <= sw_nxt;
                    code_r <= code_nxt;
                    tgt_r  <= tgt_nxt;
                    tmr_r  <= tmr_nxt;
                    pg_r   <= pg_nxt;
                end
            end

            assign o_voltage_code[g]      = code_r;
            assign o_move_active[g]       = (st_r != BDRC_IDLE) && (st_r != BDRC_OFF);
            assign o_force_pwm[g]         = (st_r == BDRC_STEP) && !i_decay_enable[g];
            assign o_allow_neg_current[g] = o_force_pwm[g];
            assign o_switching_off[g]     = (st_r == BDRC_DECAY) || (st_r == BDRC_OFF);
            assign o_soft_start[g]        = (st_r == BDRC_SOFT);
            assign o_power_good_flag[g]   = pg_r;
            assign o_high_side_on[g]      = (sw_r == BDRC_SW_HIGH);
            assign o_low_side_on[g]       = (sw_r == BDRC_SW_LOW);
        end
    endgenerate

endmodule : bdrc_buck_dvs_ramp_control

// File: tb/bdrc_sva.sv
// Checker of ramp, decay, pulse and LDO register behaviour on rail zero
`timescale 1ns/1ps
module bdrc_sva
    import bdrc_pkg::*;
#(
    parameter int NUM_RAILS = 6
) (
    input wire logic                 i_sys_clk,
    input wire logic                 i_reset_n,
    input wire logic [NUM_RAILS-1:0] i_decay_enable,
    input wire logic [7:0]           i_reg_addr,
    input wire logic [7:0]           i_reg_wdata,
    input wire logic                 i_reg_write,
    input wire logic                 i_reg_read,
    input wire logic [6:0]           o_voltage_code [NUM_RAILS],
    input wire logic [NUM_RAILS-1:0] o_force_pwm,
    input wire logic [NUM_RAILS-1:0] o_allow_neg_current,
    input wire logic [NUM_RAILS-1:0] o_switching_off,
    input wire logic [NUM_RAILS-1:0] o_move_active,
    input wire logic [NUM_RAILS-1:0] o_power_good_flag,
    input wire logic [NUM_RAILS-1:0] o_high_side_on,
    input wire logic [NUM_RAILS-1:0] o_low_side_on,
    input wire logic [7:0]           o_reg_rdata,
    input wire logic [3:0]           o_ldo_voltage_code [3],
    input wire logic [11:0]          o_ldo1_mv
);
    wire [6:0] c0 = o_voltage_code[0];
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    // Code change while stepping in forced PWM
    sequence s_stp;
        o_force_pwm[0] && $past(o_force_pwm[0]) && $changed(c0);
    endsequence
    property p_pwm; o_force_pwm[0] |-> o_move_active[0] && !i_decay_enable[0];
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm forced outside move");
    property p_neg; o_force_pwm[0] |-> o_allow_neg_current[0];
    endproperty
    a_neg: assert property (p_neg) else $error("negative current blocked");
    property p_mask; o_move_active[0] |-> !o_power_good_flag[0];
    endproperty
    a_mask: assert property (p_mask) else $error("power good not masked");
    property p_one; s_stp |-> c0 == $past(c0) + 7'h01 || c0 + 7'h01 == $past(c0);
    endproperty
    a_one: assert property (p_one) else $error("code moved more than one");
    property p_gap; s_stp |-> $past(c0, 8) == $past(c0);
    endproperty
    a_gap: assert property (p_gap) else $error("code stepped too soon");
    property p_off; o_switching_off[0] && $past(o_switching_off[0])
        |-> !o_high_side_on[0] && !o_low_side_on[0];
    endproperty
    a_off: assert property (p_off) else $error("switch on while stopped");
    property p_pulse; $fell(o_high_side_on[0]) && !o_switching_off[0] |-> o_low_side_on[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("low side missed");
    property p_lwr; i_reg_write && i_reg_addr == 8'hae
        |=> o_ldo_voltage_code[2] == $past(i_reg_wdata[3:0]);
    endproperty
    a_lwr: assert property (p_lwr) else $error("ldo code not written");
    property p_lrd; i_reg_read && i_reg_addr == 8'h9b
        |=> o_reg_rdata == {4'h0, $past(o_ldo_voltage_code[1])};
    endproperty
    a_lrd: assert property (p_lrd) else $error("ldo code read wrong");
    property p_mv; o_ldo_voltage_code[0] != BDRC_LDO1_UNUSED
        |=> o_ldo1_mv == BDRC_LDO1_MV[$past(o_ldo_voltage_code[0])];
    endproperty
    a_mv: assert property (p_mv) else $error("ldo one decode wrong");
    c_step: cover property (s_stp);
    c_decay: cover property (o_switching_off[0] && o_move_active[0]);
    c_pulse: cover property ($rose(o_low_side_on[0]));
endmodule : bdrc_sva

// File: tb/bdrc_host_model.sv
// Host model driving the LDO code register port
`timescale 1ns/1ps
module bdrc_host_model (
    input  wire logic       i_sys_clk,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata,
    output logic            o_write,
    output logic            o_read,
    input  wire logic [7:0] i_rdata
);
    initial begin
        {o_addr, o_wdata, o_write, o_read} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_wdata <= d;
        o_write <= 1'b1;
        @(posedge i_sys_clk);
        o_write <= 1'b0;
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_read <= 1'b1;
        @(posedge i_sys_clk);
        o_read <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask : rd
endmodule : bdrc_host_model

// File: tb/tb_buck_dvs_ramp_control.sv
// Bench driving rail zero and the LDO registers against a reference model
`timescale 1ns/1ps
module tb_buck_dvs_ramp_control;
    import bdrc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [6:0]  vc [6];
    logic [6:0]  oc [6];
    logic [3:0]  lc [3];
    logic [5:0]  cw, fs, de, bh, bo, bc, ecl, cl, mod, pgr, ren;
    logic [5:0]  fp, an, so, ss, ma, pg, hs, ls;
    logic [7:0]  addr, wd, rdata, r, d;
    logic        we, rd, ao, le, es, sv, lon;
    logic [11:0] mv;
    int          num_errors = 0;
    int          checks_done = 0;
    int          seed = 93978;
    int          m = 0;
    int          mvt [15] = '{1350, 1500, 1600, 1700, 1800, 1900, 2000, 2100,
                              2300, 2400, 2500, 2600, 2850, 3000, 3300};
    logic [7:0]  adr [3] = '{8'h9a, 8'h9b, 8'hae};
    always #5 clk = ~clk;
    bdrc_buck_dvs_ramp_control #(.SOFT_CYC(50)) bdrc_buck_dvs_ramp_control_inst (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_buck_voltage_code(vc), .i_code_write(cw),
        .i_fine_step(fs), .i_decay_enable(de), .i_out_below_half(bh), .i_out_below_ov(bo),
        .i_out_below_code(bc), .i_error_cmp_low(ecl), .i_current_limit(cl),
        .i_min_on_done(mod), .i_power_good_raw(pgr), .i_rail_enable(ren),
        .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_write(we), .i_reg_read(rd),
        .i_ldo1_always_on(ao), .i_ldo1_enable(le), .i_emergency_shutdown(es),
        .i_supply_valid(sv), .o_voltage_code(oc), .o_force_pwm(fp),
        .o_allow_neg_current(an), .o_switching_off(so), .o_soft_start(ss),
        .o_move_active(ma), .o_power_good_flag(pg), .o_high_side_on(hs),
        .o_low_side_on(ls), .o_reg_rdata(rdata), .o_ldo_voltage_code(lc),
        .o_ldo1_mv(mv), .o_ldo1_on(lon));
    bdrc_host_model bdrc_host_model_inst (.i_sys_clk(clk), .o_addr(addr), .o_wdata(wd),
        .o_write(we), .o_read(rd), .i_rdata(rdata));
    //--------------------------------
    // Shared tasks
    //--------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            num_errors++;
        end
    endtask : chk
    function automatic logic sg(input int w);
        logic [6:0] v;
        v = {pg[0], lon, ls[0], hs[0], so[0], ma[0], ss[0]};
        return v[w];
    endfunction : sg
    task automatic wt(input int w, input logic v, input int lim);
        int n;
        n = 0;
        while (sg(w) !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (sg(w) !== v) begin
            num_errors++;
            complete_run();
        end
    endtask : wt
    task automatic wc(input int t, input logic f, input logic dk);
        @(posedge clk);
        fs[0] <= f;
        de[0] <= dk;
        vc[0] <= 7'(t);
        cw[0] <= 1'b1;
        @(posedge clk);
        cw[0] <= 1'b0;
        #1;
    endtask : wc
    task automatic follow(input int t, input int per, input bit pgw);
        int k;
        bit first;
        first = 1'b1;
        while (m != t) begin
            k = 0;
            while (oc[0] === 7'(m) && k < 700) begin
                @(posedge clk);
                #1;
                k++;
            end
            m = (t > m) ? m + 1 : m - 1;
            chk(12'(oc[0]), 12'(m));
            if (k >= 700) complete_run();
            if (!first) chk(12'(k), 12'(per));
            if (m != t) begin
                chk({fp[0], an[0], so[0], pg[0]}, {~de[0], ~de[0], 2'b00});
            end else begin
                chk({fp[0], an[0], ma[0]}, 12'h0);
            end
            first = 1'b0;
        end
        if (pgw) begin
            wt(1, 0, 5);
            wt(6, 1, 5);
        end
    endtask : follow
    task automatic rw(input logic [7:0] wa, input logic [7:0] ra, input logic [7:0] dd);
        bdrc_host_model_inst.wr(wa, dd);
        bdrc_host_model_inst.rd(ra, r);
    endtask : rw
    //--------------------------------
    // Main sequence
    //--------------------------------
    initial begin
        int i;
        vc = '{default: 7'h00};
        {cw, de, bo, bc, ecl, cl, mod, ao, le, es} = '0;
        {fs, bh, pgr, ren, sv} = '1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({oc[0], ma[0], pg[0]}, 12'h0);
        for (i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            d[3:0] = 4'(i);
            rw(8'h9a, 8'h9a, d);
            chk(12'(r), {8'h0, d[3:0]});
            chk(mv, 12'(mvt[(i < 15) ? i : 14]));
        end
        for (i = 1; i < 4; i++) begin
            d = 8'($random(seed));
            rw(adr[i % 3], (i < 3) ? adr[i] : 8'h55, d);
            chk(12'(r), (i < 3) ? {8'h0, d[3:0]} : 12'h0);
        end
        wc(6, 1, 0);
        wt(0, 1, 6);
        chk(pg[0], 0);
        wt(0, 0, 60);
        chk(12'(oc[0]), 12'h4);
        m = 4;
        @(posedge clk);
        bh[0] <= 1'b0;
        follow(6, BDRC_STEP10_CYC, 1);
        wc(8, 0, 0);
        follow(8, BDRC_STEP25_CYC, 1);
        @(posedge clk);
        ecl[0] <= 1'b1;
        wt(3, 1, 6);
        @(posedge clk);
        ecl[0] <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(hs[0], 1);
        @(posedge clk);
        mod[0] <= 1'b1;
        wt(4, 1, 6);
        chk(hs[0], 0);
        @(posedge clk);
        mod[0] <= 1'b0;
        ecl[0] <= 1'b1;
        wt(3, 1, 6);
        @(posedge clk);
        cl[0] <= 1'b1;
        wt(4, 1, 6);
        chk(hs[0], 0);
        @(posedge clk);
        {ecl[0], cl[0]} <= 2'b00;
        wc(3, 1, 1);
        wt(2, 1, 6);
        chk({oc[0], fp[0]}, {7'h3, 1'b0});
        repeat (10) @(posedge clk);
        #1;
        chk({ma[0], pg[0], hs[0], ls[0]}, 12'h8);
        @(posedge clk);
        bo[0] <= 1'b1;
        wt(1, 0, 8);
        wt(6, 1, 5);
        m = 3;
        wc(4, 1, 1);
        follow(4, BDRC_STEP10_CYC, 1);
        @(posedge clk);
        bo[0] <= 1'b0;
        wc(2, 1, 1);
        wc(4, 1, 1);
        chk({oc[0], so[0], ma[0]}, {7'h2, 2'b11});
        repeat (300) @(posedge clk);
        #1;
        chk({oc[0], so[0]}, {7'h3, 1'b1});
        @(posedge clk);
        bc[0] <= 1'b1;
        wt(2, 0, 310);
        chk({oc[0], fp[0], ma[0]}, {7'h3, 2'b01});
        m = 3;
        follow(4, BDRC_STEP10_CYC, 1);
        wc(0, 1, 0);
        follow(1, BDRC_STEP10_CYC, 0);
        wt(2, 1, 6);
        chk(12'(oc[0]), 12'h1);
        @(posedge clk);
        {ao, le, es} <= 3'b111;
        wt(5, 1, 8);
        @(posedge clk);
        ao <= 1'b0;
        wt(5, 0, 8);
        complete_run();
    end
endmodule : tb_buck_dvs_ramp_control
bind bdrc_buck_dvs_ramp_control bdrc_sva #(.NUM_RAILS(NUM_RAILS)) bdrc_sva_inst (
    .i_sys_clk, .i_reset_n, .i_decay_enable, .i_reg_addr, .i_reg_wdata, .i_reg_write,
    .i_reg_read, .o_voltage_code, .o_force_pwm, .o_allow_neg_current, .o_switching_off,
    .o_move_active, .o_power_good_flag, .o_high_side_on, .o_low_side_on, .o_reg_rdata,
    .o_ldo_voltage_code, .o_ldo1_mv);
